// [design/pin_port_regs.vh]
`ifndef PIN_PORT_REGS_VH
`define PIN_PORT_REGS_VH
`define ADDR_W          4
`define OFS_PORT_DATA   4'h0
`define OFS_INPUT_EN    4'h4
`define OFS_PIN_OUT     4'h8
`define OFS_PIN_LEVEL   4'hc
`define OFS_PIN_DIR     4'h1
`define GROUP_STRIDE    4'h2
`define RST_INPUT_EN    8'h00
`define RST_PIN_OUT     8'h00
`define RST_PIN_DIR     8'h00
`endif

// [design/pin_slice.v]
`timescale 1ns/100ps
module pin_slice (
  input  wire       sys_clk,
  input  wire       rst,
  input  wire [7:0] pin_in,
  input  wire [7:0] pin_input_enable_bits,
  input  wire [7:0] pin_dir,
  input  wire [7:0] pin_out,
  output wire [7:0] read_value,
  output wire [7:0] drive_value,
  output wire [7:0] drive_en
);
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_bit
      assign read_value[i]  = pin_dir[i] ? pin_out[i] : (pin_input_enable_bits[i] ? pin_in[i] : 1'b1);
      assign drive_value[i] = pin_out[i];
      assign drive_en[i]    = pin_dir[i];
    end
  endgenerate
endmodule

// [design/analog_pin_digital_port.v]
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`include "pin_port_regs.vh"
module analog_pin_digital_port #(
  parameter GROUPS     = 1,
  parameter HAS_OUTPUT = 1
) (
  input  wire                 sys_clk,
  input  wire                 rst,
  input  wire [`ADDR_W-1:0]   addr,
  input  wire [7:0]           wdata,
  input  wire                 wr_stb,
  input  wire                 rd_stb,
  output reg  [7:0]           rdata_ff,
  input  wire [8*GROUPS-1:0]  pin_in,
  output reg  [8*GROUPS-1:0]  pin_out_ff,
  output reg  [8*GROUPS-1:0]  pin_oe_ff,
  output reg  [8*GROUPS-1:0]  analog_path_ff
);
  // Registers per group: enable, output latch, direction
  reg  [8*GROUPS-1:0] input_en_ff;
  reg  [8*GROUPS-1:0] pin_output_reg_ff;
  reg  [8*GROUPS-1:0] pin_direction_reg_ff;
  wire [8*GROUPS-1:0] read_value;
  wire [8*GROUPS-1:0] drive_value;
  wire [8*GROUPS-1:0] drive_en;
  reg  [7:0]          nxt_rdata;
  integer             g;
  // Separate loop index so the read mux never shares a variable with the write process
  integer             r;

  genvar k;
  generate
    for (k = 0; k < GROUPS; k = k + 1) begin : g_grp
      // each pin decoded on its own
      pin_slice u_slice (
        .sys_clk               (sys_clk),
        .rst                   (rst),
        .pin_in                (pin_in[8*k+7:8*k]),
        .pin_input_enable_bits (input_en_ff[8*k+7:8*k]),
        .pin_dir               (pin_direction_reg_ff[8*k+7:8*k]),
        .pin_out               (pin_output_reg_ff[8*k+7:8*k]),
        .read_value            (read_value[8*k+7:8*k]),
        .drive_value           (drive_value[8*k+7:8*k]),
        .drive_en              (drive_en[8*k+7:8*k])
      );
    end
  endgenerate

  // Register writes; group selected by adding group index times GROUP_STRIDE to the register offset
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      input_en_ff          <= {GROUPS{`RST_INPUT_EN}};
      pin_output_reg_ff    <= {GROUPS{`RST_PIN_OUT}};
      pin_direction_reg_ff <= {GROUPS{`RST_PIN_DIR}};
    end else if (wr_stb) begin
      for (g = 0; g < GROUPS; g = g + 1) begin
        if (addr == (`OFS_INPUT_EN + g[3:0] * `GROUP_STRIDE))
          input_en_ff[8*g +: 8] <= wdata;
        if (addr == (`OFS_PIN_OUT + g[3:0] * `GROUP_STRIDE) && HAS_OUTPUT != 0)
          pin_output_reg_ff[8*g +: 8] <= wdata;
        if (addr == (`OFS_PIN_DIR + g[3:0] * `GROUP_STRIDE) && HAS_OUTPUT != 0)
          pin_direction_reg_ff[8*g +: 8] <= wdata;
      end
    end
  end

  // Read mux; unmapped reads return zero
  always @* begin
    nxt_rdata = 8'h00;
    for (r = 0; r < GROUPS; r = r + 1) begin
      if (addr == (`OFS_PORT_DATA + r[3:0] * `GROUP_STRIDE))
        nxt_rdata = read_value[8*r +: 8];
      if (addr == (`OFS_INPUT_EN + r[3:0] * `GROUP_STRIDE))
        nxt_rdata = input_en_ff[8*r +: 8];
      if (HAS_OUTPUT != 0) begin
        if (addr == (`OFS_PIN_OUT + r[3:0] * `GROUP_STRIDE))
          nxt_rdata = read_value[8*r +: 8];
        if (addr == (`OFS_PIN_LEVEL + r[3:0] * `GROUP_STRIDE))
          nxt_rdata = read_value[8*r +: 8];
        if (addr == (`OFS_PIN_DIR + r[3:0] * `GROUP_STRIDE))
          nxt_rdata = pin_direction_reg_ff[8*r +: 8];
      end
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_ff       <= 8'h00;
      pin_out_ff     <= {8*GROUPS{1'b0}};
      pin_oe_ff      <= {8*GROUPS{1'b0}};
      analog_path_ff <= {8*GROUPS{1'b0}};
    end else begin
      rdata_ff   <= rd_stb ? nxt_rdata : 8'h00;
      // 0 is ground level, 1 supply level
      pin_out_ff <= drive_value;
      pin_oe_ff  <= (HAS_OUTPUT != 0) ? drive_en : {8*GROUPS{1'b0}};
      // analog path is independent of digital bits
      analog_path_ff <= pin_in;
    end
  end
endmodule

// [testbench/port_asserts.sv]
`timescale 1ns/100ps
`include "pin_port_regs.vh"
module port_asserts #(parameter GROUPS = 1) (
  input wire sys_clk, input wire rst, input wire [`ADDR_W-1:0] addr, input wire [7:0] wdata,
  input wire wr_stb, input wire rd_stb, input wire [7:0] rdata_ff, input wire [8*GROUPS-1:0] pin_in,
  input wire [8*GROUPS-1:0] pin_out_ff, input wire [8*GROUPS-1:0] pin_oe_ff,
  input wire [8*GROUPS-1:0] analog_path_ff
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_dir_wr; wr_stb && addr == `OFS_PIN_DIR; endsequence
  sequence s_out_wr; wr_stb && addr == `OFS_PIN_OUT; endsequence
  a_dir_to_oe: assert property (s_dir_wr |-> ##2 pin_oe_ff[7:0] == $past(wdata, 2))
    else $error("drive enable lags direction");
  a_out_drive: assert property (s_out_wr |-> ##2 pin_out_ff[7:0] == $past(wdata, 2))
    else $error("drive value wrong");
  a_oe_steady: assert property (!$past(wr_stb && addr == `OFS_PIN_DIR, 2) |-> $stable(pin_oe_ff))
    else $error("drive enable moved");
  a_rd_idle: assert property ($past(!rd_stb) |-> rdata_ff == 8'h00)
    else $error("read data outside slot");
  a_unmapped_rd: assert property (rd_stb && addr == 4'hf |=> rdata_ff == 8'h00)
    else $error("unmapped read not zero");
  a_dir_read: assert property (rd_stb && addr == `OFS_PIN_DIR && $past(!wr_stb) |=>
    rdata_ff == $past(pin_oe_ff[7:0])) else $error("direction readback wrong");
  a_out_read: assert property (rd_stb && addr == `OFS_PORT_DATA && pin_oe_ff[7:0] == 8'hff &&
    $past(!wr_stb) |=> rdata_ff == $past(pin_out_ff[7:0])) else $error("output readback wrong");
  a_analog_path: assert property ($past(!rst) |-> analog_path_ff == $past(pin_in))
    else $error("analog path wrong");
endmodule
bind analog_pin_digital_port port_asserts #(.GROUPS(GROUPS)) u_chk (.*);

// [testbench/pin_board.sv]
`timescale 1ns/100ps
module pin_board (
  input wire [7:0] board_val, input wire [7:0] pin_out_ff, input wire [7:0] pin_oe_ff, output wire [7:0] pin_level
);
  // Driven bits win, others show source
  assign pin_level = (pin_oe_ff & pin_out_ff) | (~pin_oe_ff & board_val);
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  reg sys_clk = 1'b0, rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [7:0] wdata = 8'h00, board = 8'ha5, got = 8'h00;
  wire [7:0] rdata_ff, pin_in, pin_out_ff, pin_oe_ff, analog_path_ff;
  integer err_count = 0, n_checks = 0, cyc = 0;
  always #12.5 sys_clk = ~sys_clk;
  pin_board brd (.board_val(board), .pin_out_ff(pin_out_ff), .pin_oe_ff(pin_oe_ff), .pin_level(pin_in));
  analog_pin_digital_port dut (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata_ff(rdata_ff), .pin_in(pin_in), .pin_out_ff(pin_out_ff), .pin_oe_ff(pin_oe_ff),
    .analog_path_ff(analog_path_ff));
  task check(input [7:0] seen, input [7:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    @(posedge sys_clk); wr_stb <= 1'b1; addr <= a; wdata <= d;
    @(posedge sys_clk); wr_stb <= 1'b0;
  endtask
  task rd(input [3:0] a);
    @(posedge sys_clk); rd_stb <= 1'b1; addr <= a;
    @(posedge sys_clk); rd_stb <= 1'b0;
    #1 got = rdata_ff;
  endtask
  task settle; repeat (3) @(posedge sys_clk); #1; endtask
  task finish_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task t_reset;
    rd(4'h4); check(got, 8'h00);
    rd(4'h1); check(got, 8'h00);
    check(pin_oe_ff, 8'h00);
  endtask
  task t_input;
    wr(4'h4, 8'h0f); settle;
    rd(4'h0); check(got, 8'hf5);
    rd(4'hc); check(got & 8'h0f, 8'h05);
    check(analog_path_ff, 8'ha5);
    @(posedge sys_clk); board <= 8'h5a; settle;
    rd(4'h0); check(got, 8'hfa);
    check(analog_path_ff, 8'h5a);
  endtask
  task t_output;
    wr(4'h8, 8'h3c); wr(4'h1, 8'hf0); settle;
    check(pin_oe_ff, 8'hf0);
    check(pin_out_ff & 8'hf0, 8'h30);
    rd(4'h0); check(got, 8'h3a);
    rd(4'h1); check(got, 8'hf0);
    rd(4'hf); check(got, 8'h00);
    wr(4'h1, 8'hff); settle;
    rd(4'h0); check(got, 8'h3c);
    wr(4'h1, 8'h00); settle;
    check(pin_oe_ff, 8'h00);
  endtask
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      err_count = err_count + 1;
      finish_test;
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset;
    t_input;
    t_output;
    finish_test;
  end
endmodule
